// ===== design/prs_pkg.sv
// Package of constants and types for the power-up reset sequencer.
// Contract
// - Effective reset is active when the pin is pulled low or the device drives it.
// - Device drives reset low whenever any monitored supply is under its threshold.
// - Drive is released only with all monitored supplies good and infrastructure available.
// - Supply mode is decoded from straps 0 to 2 when infrastructure appears.
// - In 5 V single supply mode both regulators soft-start before release.
// - In 3.3 V single supply only core regulator starts; 5 V is not monitored.
// - Straps 0 to 7 are captured on the rising edge of the reset pin.
// - Boot firmware starts on the rising edge of the reset pin; no user code before it completes.
// - After firmware, user code starts with the 100 MHz default clock.
// - Full external supply: no soft start; decode goes straight to HOLD, then release, then latch on the pin edge.
package prs_pkg;

    // Supply mode encodings on straps 2:0.
    localparam logic [2:0] MODE_EXT_FULL = 3'h0;
    localparam logic [2:0] MODE_5V_SINGLE = 3'h1;
    localparam logic [2:0] MODE_3V3_SINGLE = 3'h2;
    localparam logic [2:0] MODE_EXT_5V13 = 3'h3;

    localparam int STRAP_W = 8;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;

    localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;

    // Default user clock.
    localparam int DEFAULT_CLK_MHZ = 100;
    localparam int CLK_MHZ = 100;
    localparam int DEFAULT_CLK_DIV = CLK_MHZ / DEFAULT_CLK_MHZ;

    // Soft start time of a regulator, in microseconds.
    localparam int SOFTSTART_US = 1000;
    localparam int SOFTSTART_CYC = SOFTSTART_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_DECODE = 3'b001,
        ST_SOFT  = 3'b010,
        ST_HOLD  = 3'b011,
        ST_BOOT  = 3'b100,
        ST_USER  = 3'b101
    } prs_state_t;

endpackage

// ===== design/prs_sync_if.sv
// Interface carrying synchronised supply and pin levels to the sequencer core.
`timescale 1ns/100ps
interface prs_sync_if;
    logic core_ok;
    logic io_ok;
    logic ext_ok;
    logic infra_ok;
    logic pin_high;
    modport src (output core_ok, output io_ok, output ext_ok, output infra_ok, output pin_high);
    modport dst (input core_ok, input io_ok, input ext_ok, input infra_ok, input pin_high);
endinterface

// ===== design/prs_sync.sv
// Two-flop synchronisers for the asynchronous supply and pin levels.
`timescale 1ns/100ps
module prs_sync
    import prs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic [4:0] async_in,
    prs_sync_if.src  sync
);

    logic [4:0] stage1;
    logic [4:0] stage2;

    // First stage feeds only the second stage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= 5'h00;
            stage2 <= 5'h00;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync.core_ok  = stage2[0];
    assign sync.io_ok    = stage2[1];
    assign sync.ext_ok   = stage2[2];
    assign sync.infra_ok = stage2[3];
    assign sync.pin_high = stage2[4];

endmodule

// ===== design/prs_sequencer.sv
// Power-up reset sequencer: supply monitoring, reset pin drive, strap capture, boot.
`timescale 1ns/100ps
module prs_sequencer
    import prs_pkg::*;
#(
    parameter int SOFTSTART_CYCLES = SOFTSTART_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               core_supply_ok,
    input  wire logic               io_3v3_supply_ok,
    input  wire logic               main_external_supply_ok,
    input  wire logic               infra_ok,
    input  wire logic               power_on_reset_pin_in,
    output logic                    power_on_reset_pin_out,
    output logic                    power_on_reset_pin_oe,
    input  wire logic [STRAP_W-1:0] hw_config_straps,
    output logic                    core_regulator_en,
    output logic                    io_3v3_regulator_en,
    output logic [MODE_W-1:0]       supply_mode,
    output logic [STRAP_W-1:0]      straps_latched,
    output logic                    por_active,
    output logic                    firmware_run,
    input  wire logic               firmware_done,
    output logic                    user_run,
    output logic [7:0]              user_clk_mhz
);

    if (SOFTSTART_CYCLES < 1) begin : g_bad_softstart
        $error("SOFTSTART_CYCLES must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////////
    prs_sync_if sync ();

    prs_sync u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({power_on_reset_pin_in, infra_ok, main_external_supply_ok,
                    io_3v3_supply_ok, core_supply_ok}),
        .sync     (sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    prs_state_t         state;
    prs_state_t         next_state;
    logic [MODE_W-1:0]  mode;
    logic [MODE_W-1:0]  next_mode;
    logic [31:0]        count;
    logic [31:0]        next_count;
    logic [STRAP_W-1:0] straps;
    logic [STRAP_W-1:0] next_straps;
    logic               pin_prev;
    logic               supplies_ok;
    logic               drive_low;
    logic [STRAP_W-1:0] strap_stage1;
    logic [STRAP_W-1:0] strap_sync;

    // Straps are pins, so they pass two flops like the reset pin and stay aligned with its edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_stage1 <= STRAP_RST;
            strap_sync   <= STRAP_RST;
        end else begin
            strap_stage1 <= hw_config_straps;
            strap_sync   <= strap_stage1;
        end
    end

    // The 5 V domain is ignored in 3.3 V single supply mode. Only levels are used,
    // so the ramp order of external rails never matters.
    always_comb begin
        if (state != ST_OFF && state != ST_DECODE && mode == MODE_3V3_SINGLE) begin
            supplies_ok = sync.core_ok & sync.io_ok;
        end else begin
            supplies_ok = sync.core_ok & sync.io_ok & sync.ext_ok;
        end
    end

    always_comb begin
        next_state  = state;
        next_mode   = mode;
        next_count  = count;
        next_straps = straps;
        case (state)
            ST_OFF: begin
                if (sync.infra_ok) begin
                    next_state = ST_DECODE;
                end
            end
            ST_DECODE: begin
                next_mode  = strap_sync[MODE_LSB +: MODE_W];
                next_count = 32'h0;
                if (strap_sync[MODE_LSB +: MODE_W] == MODE_5V_SINGLE ||
                    strap_sync[MODE_LSB +: MODE_W] == MODE_3V3_SINGLE) begin
                    next_state = ST_SOFT;
                end else begin
                    next_state = ST_HOLD;
                end
            end
            ST_SOFT: begin
                if (count < SOFTSTART_CYCLES - 1) begin
                    next_count = count + 32'h1;
                end else begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (supplies_ok && sync.infra_ok && sync.pin_high && !pin_prev) begin
                    next_straps = strap_sync;
                    next_state  = ST_BOOT;
                end
            end
            ST_BOOT: begin
                if (firmware_done) begin
                    next_state = ST_USER;
                end
            end
            ST_USER: begin
                next_state = ST_USER;
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        // Rails fed by the on-chip regulators are still low during soft start, so a bad
        // supply only restarts the sequence in BOOT or USER; before that the drive just holds.
        if (state != ST_OFF && !sync.infra_ok) begin
            next_state = ST_OFF;
        end else if ((state == ST_BOOT || state == ST_USER) && !supplies_ok) begin
            next_state = ST_OFF;
        end else if ((state == ST_BOOT || state == ST_USER) && !sync.pin_high) begin
            next_state = ST_OFF;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= ST_OFF;
            mode     <= MODE_EXT_FULL;
            count    <= 32'h0;
            straps   <= STRAP_RST;
            pin_prev <= 1'b0;
        end else begin
            state    <= next_state;
            mode     <= next_mode;
            count    <= next_count;
            straps   <= next_straps;
            pin_prev <= sync.pin_high;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Drive is released in HOLD once supplies are good so the pin can rise.
    assign drive_low = (state == ST_OFF) || (state == ST_DECODE) || (state == ST_SOFT) ||
                       !supplies_ok || !sync.infra_ok;

    assign power_on_reset_pin_out = 1'b0;
    assign power_on_reset_pin_oe  = drive_low;
    assign por_active             = drive_low || !sync.pin_high;
    assign core_regulator_en      = (state != ST_OFF) && (state != ST_DECODE) &&
                                    (mode == MODE_5V_SINGLE || mode == MODE_3V3_SINGLE);
    assign io_3v3_regulator_en    = (state != ST_OFF) && (state != ST_DECODE) &&
                                    (mode == MODE_5V_SINGLE);
    assign supply_mode            = mode;
    assign straps_latched         = straps;
    assign firmware_run           = (state == ST_BOOT);
    assign user_run               = (state == ST_USER);
    assign user_clk_mhz           = 8'(DEFAULT_CLK_MHZ);

    ////////////////////////////////////////////////////////////////////////////////
    sequence fw_phase;
        state == ST_BOOT;
    endsequence

    sequence rails_up;
        supplies_ok && sync.infra_ok && sync.pin_high;
    endsequence

    hold_drive_a: assert property (@(posedge clk) disable iff (rst)
        !supplies_ok |-> power_on_reset_pin_oe)
        else $error("reset pin not driven with a bad supply");
    release_cond_a: assert property (@(posedge clk) disable iff (rst)
        !power_on_reset_pin_oe |-> supplies_ok && sync.infra_ok)
        else $error("drive released too early");
    por_or_a: assert property (@(posedge clk) disable iff (rst)
        !sync.pin_high |-> por_active)
        else $error("external reset not reflected");
    strap_cap_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_HOLD && next_state == ST_BOOT) |=> straps == $past(strap_sync))
        else $error("straps not captured");
    user_after_a: assert property (@(posedge clk) disable iff (rst)
        $rose(user_run) |-> $past(firmware_run) && $past(firmware_done))
        else $error("user code without firmware");
    fw_start_a: assert property (@(posedge clk) disable iff (rst)
        $rose(firmware_run) |-> $past(state) == ST_HOLD)
        else $error("firmware start out of order");
    boot_to_user_a: assert property (@(posedge clk) disable iff (rst)
        fw_phase ##0 rails_up ##0 firmware_done |=> user_run && user_clk_mhz == 8'h64)
        else $error("user code not started");
    ext_nosoft_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_DECODE && strap_sync[MODE_LSB +: MODE_W] == MODE_EXT_FULL && supplies_ok)
        |=> state != ST_SOFT && !core_regulator_en)
        else $error("soft start in external mode");
    soft_both_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_SOFT && mode == MODE_5V_SINGLE |-> core_regulator_en && io_3v3_regulator_en)
        else $error("regulators not started");
    soft_core_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_SOFT && mode == MODE_3V3_SINGLE |-> core_regulator_en && !io_3v3_regulator_en)
        else $error("wrong regulator in 3.3 V mode");
    decode_mode_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_DECODE |=> supply_mode == $past(strap_sync[MODE_LSB +: MODE_W]))
        else $error("supply mode not decoded");
    soft_len_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_SOFT && count < SOFTSTART_CYCLES - 1 && sync.infra_ok |=> state == ST_SOFT)
        else $error("soft start cut short");
    loss_restart_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_BOOT || state == ST_USER) && !supplies_ok |=> state == ST_OFF)
        else $error("supply loss did not restart");
    pin_restart_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_BOOT || state == ST_USER) && !sync.pin_high |=> state == ST_OFF)
        else $error("external reset ignored");
    fw_wait_a: assert property (@(posedge clk) disable iff (rst)
        fw_phase ##0 rails_up ##0 !firmware_done |=> firmware_run && !user_run)
        else $error("firmware phase cut short");
    user_stay_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_USER) ##0 rails_up |=> user_run && user_clk_mhz == 8'h64)
        else $error("user code stopped");

endmodule

// ===== dv/prs_supervisor.sv
// Behavioural external supervisor on the far side of the reset pin.
`timescale 1ns/100ps
module prs_supervisor (
    input  wire logic       clk,
    input  wire logic       supply_good,
    input  wire logic [7:0] hold_cycles,
    input  wire logic       device_pull_low,
    output logic            pin_level
);
    logic [7:0] count;
    logic       holding;
    initial count = 8'h00;
    // The count restarts on every supply loss, so a glitchy rail re-arms the hold.
    always @(posedge clk) begin
        if (!supply_good) begin
            count <= 8'h00;
        end else if (count != 8'hff) begin
            count <= count + 8'h01;
        end
    end
    assign holding = !supply_good || (count < hold_cycles);
    // The pin has a pull-up, and either party pulling it low wins.
    assign pin_level = !(holding || device_pull_low);
endmodule

// ===== dv/power_up_reset_sequencer_test.sv
// Self-checking testbench for the power-up reset sequencer.
`timescale 1ns/100ps
module power_up_reset_sequencer_test;
    import prs_pkg::*;
    logic         clk, rst, core_ok, io_ok, ext_ok, infra, pin, fw_done, sup_good;
    logic         oe, pout, core_en, io_en, por, fw_run, usr, ever_core, ever_io;
    logic [7:0]   straps, latched, mhz, hold;
    logic [2:0]   mode;
    logic [31:0]  seed;
    logic [7:0]   exp_q[$];
    int           fail_count, comparisons;
    ////////////////////////////////////////////////////////////////////////////////
    prs_sequencer #(.SOFTSTART_CYCLES(5)) u_prs_sequencer (.clk(clk), .rst(rst),
        .core_supply_ok(core_ok), .io_3v3_supply_ok(io_ok), .main_external_supply_ok(ext_ok),
        .infra_ok(infra), .power_on_reset_pin_in(pin), .power_on_reset_pin_out(pout),
        .power_on_reset_pin_oe(oe), .hw_config_straps(straps), .core_regulator_en(core_en),
        .io_3v3_regulator_en(io_en), .supply_mode(mode), .straps_latched(latched),
        .por_active(por), .firmware_run(fw_run), .firmware_done(fw_done), .user_run(usr),
        .user_clk_mhz(mhz));
    prs_supervisor u_prs_supervisor (.clk(clk), .supply_good(sup_good), .hold_cycles(hold),
        .device_pull_low(oe && !pout), .pin_level(pin));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic run_mode(input logic [2:0] m);
        int n;
        seed = xs(seed);
        @(posedge clk);
        straps <= {seed[7:3], m};
        exp_q.push_back({seed[7:3], m});
        hold <= 8'h20 + {3'h0, seed[12:8]};
        sup_good <= 1'b1;
        // Rails come up in a seed-chosen order; only the levels may matter.
        @(posedge clk);
        if (seed[16]) core_ok <= 1'b1; else io_ok <= 1'b1;
        @(posedge clk);
        if (seed[16]) io_ok <= 1'b1; else ext_ok <= 1'b1;
        // Rails made by the on-chip regulators stay low until their regulator is enabled.
        @(posedge clk);
        {core_ok, io_ok, ext_ok, infra} <= {m != 3'h1 && m != 3'h2, m != 3'h1, 2'b11};
        {ever_core, ever_io} = 2'b00;
        n = 0;
        while (oe !== 1'b0 && n < 200) begin
            @(posedge clk);
            core_ok <= core_ok | ever_core;
            io_ok <= io_ok | ever_io;
            @(negedge clk);
            n++;
            ever_core |= core_en;
            ever_io |= io_en;
        end
        chk(ever_core, m == 3'h1 || m == 3'h2);
        chk(ever_io, m == 3'h1);
        chk(oe, 1'b0);
        chk(pout, 1'b0);
        chk({por, fw_run}, 2'b10);
        n = 0;
        while (fw_run !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
            chk(usr, 1'b0);
        end
        @(posedge clk);
        straps <= ~straps;
        @(negedge clk);
        chk(mode, {5'h0, m});
        chk(latched, exp_q.pop_front());
        chk({fw_run, usr, por}, 3'b100);
        @(posedge clk);
        fw_done <= 1'b1;
        repeat (3) @(negedge clk);
        chk({fw_run, usr}, 2'b01);
        chk(mhz, 8'h64);
        @(posedge clk);
        fw_done <= 1'b0;
        if (m == 3'h2) begin
            ext_ok <= 1'b0;
            repeat (6) @(negedge clk);
            chk({usr, oe}, 2'b10);
        end
        @(posedge clk);
        core_ok <= 1'b0;
        repeat (4) @(negedge clk);
        chk({oe, por, usr}, 3'b110);
        @(posedge clk);
        {io_ok, ext_ok, infra, sup_good} <= 4'h0;
        repeat (4) @(negedge clk);
        $display("Mode %0d test done", m);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #40000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        {rst, core_ok, io_ok, ext_ok, infra, fw_done, sup_good} = 7'h40;
        {straps, hold, seed} = {8'h00, 8'h20, 32'h5dcb7db5};
        {fail_count, comparisons} = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Mode 3 first checks that decode replaces the reset mode before modes 0 to 2 run.
        run_mode(3'h3);
        for (int i = 0; i < 3; i++) run_mode(i[2:0]);
        report_and_stop();
    end
endmodule
